// File: rtl/irq_vec_pkg.sv
// shared constants and types for the reset and interrupt vectoring block
package irq_vec_pkg;
    // register byte addresses
    localparam logic [7:0]  ADDR_SERIAL_STATUS = 8'h2E;
    localparam logic [7:0]  ADDR_SERIAL_DATA   = 8'h2F;
    localparam logic [7:0]  ADDR_SYS_OPTIONS   = 8'h39;
    localparam logic [7:0]  ADDR_PROMOTED_SEL  = 8'h3C;
    // system_options and serial status field positions
    localparam int          OPT_CONV_PWR_BIT   = 7;
    localparam int          OPT_CONV_CLK_BIT   = 6;
    localparam int          OPT_EDGE_SEL_BIT   = 5;
    localparam int          OPT_EXIT_DELAY_BIT = 4;
    localparam int          OPT_MON_ON_BIT     = 3;
    localparam int          OPT_MON_FORCE_BIT  = 2;
    localparam int          OPT_RATE_HI        = 1;
    localparam int          OPT_RATE_LO        = 0;
    localparam int          STAT_RX_FULL_BIT = 5;
    // reset values
    localparam logic [7:0]  SYS_OPTIONS_RESET = 8'h10;
    localparam logic [4:0]  PROMOTED_RESET    = 5'h06;
    // vector codes: vector address = FFFE minus twice the code
    localparam logic [4:0]  CODE_EXT_RESET  = 5'h00;
    localparam logic [4:0]  CODE_CLK_FAIL   = 5'h01;
    localparam logic [4:0]  CODE_WDOG_FAIL  = 5'h02;
    localparam logic [4:0]  CODE_ILLEGAL_OP = 5'h03;
    localparam logic [4:0]  CODE_SW_INT     = 5'h04;
    localparam logic [4:0]  CODE_X_PIN      = 5'h05;
    localparam logic [4:0]  CODE_EXT_IRQ    = 5'h06;
    localparam logic [4:0]  CODE_SERIAL     = 5'h14;
    localparam logic [4:0]  CODE_LAST       = 5'h14;
    localparam logic [15:0] VEC_TOP         = 16'hFFFE;
    localparam logic [9:0]  VEC_TABLE_PAGE  = 10'h3FF;
    localparam int          NUM_MASKABLE    = 19;
    localparam int          NUM_TIMER       = 9;
    localparam int          FIRST_SERIAL    = 14;
    // handler address page, arbitrary value
    localparam logic [2:0]  HANDLER_PAGE    = 3'h4;
    // timing: clock period and stop delay in ns, counts in clock cycles
    localparam int          CLK_PERIOD_NS      = 10;
    localparam logic [6:0]  BOOT_WINDOW_CYCLES = 7'h40;
    localparam int          STOP_DELAY_NS      = 40000;
    localparam logic [11:0] STOP_DELAY_CYCLES  =
        12'((STOP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // receive-full clearing sequence
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b01,
        RX_ARMED = 2'b10
    } rx_seq_t;
endpackage : irq_vec_pkg

// File: rtl/bit_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module bit_sync #(
    parameter int         WIDTH = 2,
    parameter logic [1:0] IDLE  = 2'h3
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= IDLE;
            q    <= IDLE;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : bit_sync

// File: rtl/reset_irq_vectoring.sv
// reset and interrupt vectoring with system options and promotion select
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module reset_irq_vectoring
    import irq_vec_pkg::*;
(
    // clock and reset
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST_N,
    // register port
    input  wire logic [7:0]           ADDR,
    input  wire logic [7:0]           WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output logic      [7:0]           RDATA,
    // core status
    input  wire logic                 GLOBAL_IRQ_MASK,
    input  wire logic                 X_MASK,
    input  wire logic                 SPECIAL_MODE,
    input  wire logic                 ILLEGAL_OP,
    input  wire logic                 SW_INT,
    input  wire logic                 VEC_ACK,
    // vector fetch
    input  wire logic                 VEC_FETCH,
    input  wire logic [15:0]          VEC_FETCH_ADDR,
    output logic      [7:0]           VEC_DATA,
    output logic                      VEC_PENDING,
    output logic      [15:0]          VEC_ADDR,
    // reset sources
    input  wire logic                 CLK_MON_FAIL,
    input  wire logic                 WATCHDOG_FAIL,
    input  wire logic                 WATCHDOG_DISABLE,
    output logic                      SYS_RESET_REQ,
    // pins, active low
    input  wire logic                 IRQ_N,
    input  wire logic                 X_PIN_N,
    // peripheral flags and enables
    input  wire logic                 TICK_FLAG,
    input  wire logic                 PERIODIC_TICK_IRQ_EN,
    input  wire logic [NUM_TIMER-1:0] TIMER_FLAG,
    input  wire logic [NUM_TIMER-1:0] TIMER_IRQ_EN,
    input  wire logic                 PULSE_OVF_FLAG,
    input  wire logic                 PULSE_COUNT_OVF_IRQ_EN,
    input  wire logic                 PULSE_EDGE_FLAG,
    input  wire logic                 PULSE_EDGE_IRQ_EN,
    input  wire logic                 SPI_DONE_FLAG,
    input  wire logic                 SERIAL_PERIPH_DONE_IRQ_EN,
    input  wire logic                 RX_FULL_SET,
    input  wire logic                 OVERRUN_FLAG,
    input  wire logic                 TX_EMPTY_FLAG,
    input  wire logic                 TX_DONE_FLAG,
    input  wire logic                 IDLE_FLAG,
    input  wire logic                 RX_FULL_IRQ_EN,
    input  wire logic                 TX_EMPTY_IRQ_EN,
    input  wire logic                 TX_DONE_IRQ_EN,
    input  wire logic                 IDLE_LINE_IRQ_EN,
    output logic                      RX_FULL,
    // stop mode
    input  wire logic                 STOP_EXIT,
    output logic                      RESUME,
    // option outputs
    output logic                      CONV_POWER_UP,
    output logic                      CONV_CLOCK_SOURCE_SEL,
    output logic      [1:0]           WATCHDOG_RATE_SEL,
    output logic                      CLK_MON_ACTIVE
);
    typedef struct packed {
        logic [7:0]  opt;
        logic        once_done;
        logic [6:0]  boot_cnt;
        logic        mon_forced;
        logic [4:0]  psel;
        logic        rx_full;
        rx_seq_t     rx_seq;
        logic [1:0]  pin_s3;
        logic [1:0]  pin_filt;
        logic        irq_edge;
        logic        rst_pend;
        logic [4:0]  rst_code;
        logic [11:0] stop_cnt;
        logic        resume;
        logic        sys_reset_req;
        logic        vec_pending;
        logic [4:0]  vec_code;
        logic [15:0] vec_addr;
        logic [7:0]  vec_data;
        logic [7:0]  rdata;
        logic        clk_mon_active;
    } state_t;

    localparam state_t STATE_RESET = '{
        opt: SYS_OPTIONS_RESET, once_done: 1'b0, boot_cnt: 7'h00,
        mon_forced: 1'b0, psel: PROMOTED_RESET, rx_full: 1'b0,
        rx_seq: RX_IDLE, pin_s3: 2'h3, pin_filt: 2'h3, irq_edge: 1'b0,
        rst_pend: 1'b1, rst_code: CODE_EXT_RESET, stop_cnt: 12'h000,
        resume: 1'b0, sys_reset_req: 1'b0, vec_pending: 1'b0,
        vec_code: 5'h00, vec_addr: 16'h0000, vec_data: 8'h00,
        rdata: 8'h00, clk_mon_active: 1'b0
    };

    logic                    rst_meta;
    logic                    rst_n;
    logic [1:0]              pin_s2;
    logic [NUM_MASKABLE-1:0] pend;
    state_t                  s;
    state_t                  next_s;

    // reset released through two flops, asserted at once
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // bit 1 is the external pin, bit 0 the x pin
    bit_sync #(.WIDTH(2), .IDLE(2'h3)) u_pin_sync (
        .clk   (SYS_CLK),
        .rst_n (rst_n),
        .d     ({IRQ_N, X_PIN_N}),
        .q     (pin_s2)
    );

    always_comb
    begin
        logic        ext_req;
        logic        wr_opt;
        logic        protect_ok;
        logic [4:0]  best;
        logic [4:0]  psel_eff;
        logic        promo_hit;
        logic [4:0]  code;
        logic [4:0]  fcode;
        logic [15:0] handler;
        ext_req    = 1'b0;
        wr_opt     = 1'b0;
        protect_ok = 1'b0;
        best       = 5'h00;
        psel_eff   = 5'h00;
        promo_hit  = 1'b0;
        code       = 5'h00;
        fcode      = 5'h00;
        handler    = 16'h0000;
        next_s     = s;

        // third stage; a level counts once stages two and three agree
        next_s.pin_s3 = pin_s2;
        for (int i = 0; i < 2; i++)
        begin
            if (pin_s2[i] == s.pin_s3[i])
                next_s.pin_filt[i] = s.pin_s3[i];
        end
        // falling edge latch; set wins over the acknowledge
        if (s.vec_pending && VEC_ACK && s.vec_code == CODE_EXT_IRQ)
            next_s.irq_edge = 1'b0;
        if (s.pin_filt[1] && !next_s.pin_filt[1])
            next_s.irq_edge = 1'b1;
        ext_req = s.opt[OPT_EDGE_SEL_BIT] ? s.irq_edge : !s.pin_filt[1];

        // maskable requests gated by local enables, pin has none
        pend[0]  = ext_req;
        pend[1]  = TICK_FLAG && PERIODIC_TICK_IRQ_EN;
        pend[10:2] = TIMER_FLAG & TIMER_IRQ_EN;
        pend[11] = PULSE_OVF_FLAG && PULSE_COUNT_OVF_IRQ_EN;
        pend[12] = PULSE_EDGE_FLAG && PULSE_EDGE_IRQ_EN;
        pend[13] = SPI_DONE_FLAG && SERIAL_PERIPH_DONE_IRQ_EN;
        pend[14] = s.rx_full && RX_FULL_IRQ_EN;
        pend[15] = OVERRUN_FLAG && RX_FULL_IRQ_EN;
        pend[16] = TX_EMPTY_FLAG && TX_EMPTY_IRQ_EN;
        pend[17] = TX_DONE_FLAG && TX_DONE_IRQ_EN;
        pend[18] = IDLE_FLAG && IDLE_LINE_IRQ_EN;

        // fixed order, lowest index first; serial group folds to one code
        for (int i = NUM_MASKABLE - 1; i >= 0; i--)
        begin
            if (pend[i])
                best = (i >= FIRST_SERIAL) ? CODE_SERIAL : 5'(i + 6);
        end
        psel_eff = (s.psel >= CODE_EXT_IRQ && s.psel <= CODE_LAST)
                 ? s.psel : CODE_EXT_IRQ;
        if (psel_eff == CODE_SERIAL)
            promo_hit = |pend[NUM_MASKABLE-1:FIRST_SERIAL];
        else
            promo_hit = pend[5'(psel_eff - CODE_EXT_IRQ)];

        // arbitration: resets, instruction traps, x pin, then maskable
        if (s.rst_pend)
            code = s.rst_code;
        else if (ILLEGAL_OP)
            code = CODE_ILLEGAL_OP;
        else if (SW_INT)
            code = CODE_SW_INT;
        else if (!s.pin_filt[0] && !X_MASK)
            code = CODE_X_PIN;
        else if (!GLOBAL_IRQ_MASK && promo_hit)
            code = psel_eff;
        else
            code = best;
        next_s.vec_pending = s.rst_pend || ILLEGAL_OP || SW_INT
                           || (!s.pin_filt[0] && !X_MASK)
                           || (!GLOBAL_IRQ_MASK && |pend);
        next_s.vec_code = code;
        next_s.vec_addr = VEC_TOP - {10'h000, code, 1'b0};

        // reset causes; the lower number keeps the slot
        if (s.rst_pend && VEC_ACK && s.vec_code == s.rst_code)
            next_s.rst_pend = 1'b0;
        next_s.sys_reset_req = 1'b0;
        if (WATCHDOG_FAIL && !WATCHDOG_DISABLE
            && !(next_s.rst_pend && next_s.rst_code < CODE_WDOG_FAIL))
        begin
            next_s.rst_pend      = 1'b1;
            next_s.rst_code      = CODE_WDOG_FAIL;
            next_s.sys_reset_req = 1'b1;
        end
        if (CLK_MON_FAIL && s.clk_mon_active
            && !(next_s.rst_pend && next_s.rst_code == CODE_EXT_RESET))
        begin
            next_s.rst_pend      = 1'b1;
            next_s.rst_code      = CODE_CLK_FAIL;
            next_s.sys_reset_req = 1'b1;
        end

        // forced monitor latches until reset
        if (s.opt[OPT_MON_FORCE_BIT])
            next_s.mon_forced = 1'b1;
        next_s.clk_mon_active = s.opt[OPT_MON_ON_BIT] || s.mon_forced;

        // boot window counter stops at its end
        if (s.boot_cnt < BOOT_WINDOW_CYCLES)
            next_s.boot_cnt = s.boot_cnt + 7'h01;

        // register writes
        wr_opt     = WR && ADDR == ADDR_SYS_OPTIONS;
        protect_ok = SPECIAL_MODE
                   || (!s.once_done && s.boot_cnt < BOOT_WINDOW_CYCLES);
        if (wr_opt)
        begin
            next_s.opt[OPT_CONV_PWR_BIT] = WDATA[OPT_CONV_PWR_BIT];
            next_s.opt[OPT_CONV_CLK_BIT] = WDATA[OPT_CONV_CLK_BIT];
            next_s.opt[OPT_MON_ON_BIT]   = WDATA[OPT_MON_ON_BIT];
            if (protect_ok)
            begin
                next_s.opt[OPT_EDGE_SEL_BIT]   = WDATA[OPT_EDGE_SEL_BIT];
                next_s.opt[OPT_EXIT_DELAY_BIT] = WDATA[OPT_EXIT_DELAY_BIT];
                next_s.opt[OPT_MON_FORCE_BIT]  = WDATA[OPT_MON_FORCE_BIT];
                next_s.opt[OPT_RATE_HI:OPT_RATE_LO] = WDATA[OPT_RATE_HI:OPT_RATE_LO];
                next_s.once_done = !SPECIAL_MODE;
            end
        end
        // a write with interrupts enabled is dropped silently
        if (WR && ADDR == ADDR_PROMOTED_SEL && GLOBAL_IRQ_MASK)
            next_s.psel = WDATA[4:0];

        // receive full: status read while set, then data read clears it
        case (s.rx_seq)
            RX_IDLE:
            begin
                if (RD && ADDR == ADDR_SERIAL_STATUS && s.rx_full)
                    next_s.rx_seq = RX_ARMED;
            end
            RX_ARMED:
            begin
                if (RD && ADDR == ADDR_SERIAL_DATA)
                begin
                    next_s.rx_full = 1'b0;
                    next_s.rx_seq  = RX_IDLE;
                end
            end
            default:
                next_s.rx_seq = RX_IDLE;
        endcase
        if (RX_FULL_SET)
            next_s.rx_full = 1'b1;

        // register reads, one cycle later; unmapped reads as zero
        next_s.rdata = 8'h00;
        if (RD)
        begin
            case (ADDR)
                ADDR_SYS_OPTIONS:   next_s.rdata = s.opt;
                ADDR_PROMOTED_SEL:  next_s.rdata = {3'h0, s.psel};
                ADDR_SERIAL_STATUS: next_s.rdata = 8'(s.rx_full) << STAT_RX_FULL_BIT;
                default:            next_s.rdata = 8'h00;
            endcase
        end

        // vector table: slot code from the address, high byte first
        next_s.vec_data = 8'h00;
        fcode   = ~VEC_FETCH_ADDR[5:1];
        handler = {HANDLER_PAGE, fcode, 8'h00};
        if (VEC_FETCH && VEC_FETCH_ADDR[15:6] == VEC_TABLE_PAGE && fcode <= CODE_LAST)
            next_s.vec_data = VEC_FETCH_ADDR[0] ? handler[7:0] : handler[15:8];

        // stop exit: count the stabilisation delay only when enabled
        next_s.resume = 1'b0;
        if (s.stop_cnt != 12'h000)
        begin
            next_s.stop_cnt = s.stop_cnt - 12'h001;
            next_s.resume   = s.stop_cnt == 12'h001;
        end
        else if (STOP_EXIT)
        begin
            if (s.opt[OPT_EXIT_DELAY_BIT])
                next_s.stop_cnt = STOP_DELAY_CYCLES;
            else
                next_s.resume = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
            s <= STATE_RESET;
        else
            s <= next_s;
    end

    assign RDATA                 = s.rdata;
    assign VEC_DATA              = s.vec_data;
    assign VEC_PENDING           = s.vec_pending;
    assign VEC_ADDR              = s.vec_addr;
    assign SYS_RESET_REQ         = s.sys_reset_req;
    assign RX_FULL               = s.rx_full;
    assign RESUME                = s.resume;
    assign CONV_POWER_UP         = s.opt[OPT_CONV_PWR_BIT];
    assign CONV_CLOCK_SOURCE_SEL = s.opt[OPT_CONV_CLK_BIT];
    assign WATCHDOG_RATE_SEL     = s.opt[OPT_RATE_HI:OPT_RATE_LO];
    assign CLK_MON_ACTIVE        = s.clk_mon_active;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    sequence s_status_read;
        RD && ADDR == ADDR_SERIAL_STATUS && s.rx_full && s.rx_seq == RX_IDLE;
    endsequence
    sequence s_data_read;
        RD && ADDR == ADDR_SERIAL_DATA && !RX_FULL_SET;
    endsequence

    property p_global_mask;
        $past(GLOBAL_IRQ_MASK) |-> !(s.vec_pending && s.vec_addr <= 16'hFFF2);
    endproperty
    a_global_mask: assert property (p_global_mask) else $error("masked request taken");

    property p_promote_write;
        WR && ADDR == ADDR_PROMOTED_SEL && GLOBAL_IRQ_MASK |=> s.psel == $past(WDATA[4:0]);
    endproperty
    a_promote_write: assert property (p_promote_write) else $error("select not stored");

    property p_promote_lock;
        WR && ADDR == ADDR_PROMOTED_SEL && !GLOBAL_IRQ_MASK |=> $stable(s.psel);
    endproperty
    a_promote_lock: assert property (p_promote_lock) else $error("select changed");

    property p_once;
        (s.once_done || s.boot_cnt == BOOT_WINDOW_CYCLES) && !SPECIAL_MODE
        && WR && ADDR == ADDR_SYS_OPTIONS
        |=> $stable(s.opt[OPT_EDGE_SEL_BIT:OPT_EXIT_DELAY_BIT])
            && $stable(s.opt[OPT_MON_FORCE_BIT:OPT_RATE_LO]);
    endproperty
    a_once: assert property (p_once) else $error("protected bit written late");

    property p_rx_clear;
        s_status_read ##1 !RD ##1 s_data_read |=> !s.rx_full;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("receive full not cleared");

    property p_force_monitor;
        s.mon_forced |=> s.clk_mon_active;
    endproperty
    a_force_monitor: assert property (p_force_monitor) else $error("monitor off");

    property p_no_delay;
        STOP_EXIT && !s.opt[OPT_EXIT_DELAY_BIT] && s.stop_cnt == 12'h000 |=> s.resume;
    endproperty
    a_no_delay: assert property (p_no_delay) else $error("resume late");

    property p_delay;
        STOP_EXIT && s.opt[OPT_EXIT_DELAY_BIT] && s.stop_cnt == 12'h000 |=> !s.resume [*8];
    endproperty
    a_delay: assert property (p_delay) else $error("delay skipped");

    property p_vec_bytes;
        VEC_FETCH && VEC_FETCH_ADDR == 16'hFFF2 |=> VEC_DATA == {HANDLER_PAGE, 5'h06};
    endproperty
    a_vec_bytes: assert property (p_vec_bytes) else $error("wrong high byte");

    property p_wdog_vec;
        WATCHDOG_FAIL && !WATCHDOG_DISABLE && !s.rst_pend && !CLK_MON_FAIL
        |=> ##1 s.vec_addr == 16'hFFFA;
    endproperty
    a_wdog_vec: assert property (p_wdog_vec) else $error("wrong reset vector");
endmodule : reset_irq_vectoring

// File: verification/core_fetch_model.sv
// core model: fetches the pending vector pair, then acknowledges it
`timescale 1ns/1ps
module core_fetch_model
(
    // clock and request
    input  wire logic        clk,
    input  wire logic        take,
    // vector side
    input  wire logic [15:0] vec_addr,
    input  wire logic [7:0]  vec_data,
    output logic             vec_fetch = 1'b0,
    output logic      [15:0] vec_fetch_addr = 16'h0000,
    output logic             vec_ack = 1'b0,
    output logic      [15:0] handler
);
    logic [1:0] step = 2'h0;
    logic       go;
    assign go = (take && step == 2'h0) || step == 2'h1;
    always @(posedge clk)
    begin
        step <= (take || step != 2'h0) ? step + 2'h1 : step;
        vec_fetch <= go;
        // idle bus toggles so a stale address never passes
        vec_fetch_addr <= go ? (vec_addr | {15'h0000, step[0]}) : ~vec_fetch_addr;
        if (step[1])
            handler <= {handler[7:0], vec_data};
        vec_ack <= step == 2'h3;
    end
endmodule : core_fetch_model

// File: verification/reset_irq_vectoring_test.sv
// self-checking bench for the reset and interrupt vectoring block
`timescale 1ns/1ps
`define CHK(g, x) \
    begin total_checks++; if ((g) !== (x)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (x)); end end
module reset_irq_vectoring_test
    import irq_vec_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, take = 1'b0;
    logic        imask = 1'b1, xmask = 1'b1, ill = 1'b0, swi = 1'b0, cmf = 1'b0, wdf = 1'b0;
    logic        irq_n = 1'b1, xpin_n = 1'b1, rxs = 1'b0, stp = 1'b0, spec = 1'b0;
    logic [7:0]  a = 8'h00, wd = 8'h00, rdat, vdat;
    logic [16:0] fl = 17'h00000, en = 17'h00000;
    logic        fetch, ack, pend, resume, rx_full, mon, sreq;
    logic [3:0]  optq;
    logic [15:0] faddr, vaddr, handler;
    logic [31:0] exq[$];
    logic [31:0] e;
    int          n_fail = 0;
    int          total_checks = 0;
    reset_irq_vectoring i_reset_irq_vectoring (
        .SYS_CLK(clk), .RST_N(rst_n), .ADDR(a), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdat),
        .GLOBAL_IRQ_MASK(imask), .X_MASK(xmask), .SPECIAL_MODE(spec), .ILLEGAL_OP(ill),
        .SW_INT(swi), .VEC_ACK(ack), .VEC_FETCH(fetch), .VEC_FETCH_ADDR(faddr),
        .VEC_DATA(vdat), .VEC_PENDING(pend), .VEC_ADDR(vaddr), .CLK_MON_FAIL(cmf),
        .WATCHDOG_FAIL(wdf), .WATCHDOG_DISABLE(1'b0), .SYS_RESET_REQ(sreq), .IRQ_N(irq_n),
        .X_PIN_N(xpin_n), .TICK_FLAG(fl[0]), .PERIODIC_TICK_IRQ_EN(en[0]),
        .TIMER_FLAG(fl[9:1]), .TIMER_IRQ_EN(en[9:1]), .PULSE_OVF_FLAG(fl[10]),
        .PULSE_COUNT_OVF_IRQ_EN(en[10]), .PULSE_EDGE_FLAG(fl[11]), .PULSE_EDGE_IRQ_EN(en[11]),
        .SPI_DONE_FLAG(fl[12]), .SERIAL_PERIPH_DONE_IRQ_EN(en[12]), .RX_FULL_SET(rxs),
        .OVERRUN_FLAG(fl[13]), .TX_EMPTY_FLAG(fl[14]), .TX_DONE_FLAG(fl[15]),
        .IDLE_FLAG(fl[16]), .RX_FULL_IRQ_EN(en[13]), .TX_EMPTY_IRQ_EN(en[14]),
        .TX_DONE_IRQ_EN(en[15]), .IDLE_LINE_IRQ_EN(en[16]), .RX_FULL(rx_full),
        .STOP_EXIT(stp), .RESUME(resume), .CONV_POWER_UP(optq[3]),
        .CONV_CLOCK_SOURCE_SEL(optq[2]), .WATCHDOG_RATE_SEL(optq[1:0]), .CLK_MON_ACTIVE(mon));
    core_fetch_model i_core_fetch_model (.clk(clk), .take(take), .vec_addr(vaddr),
        .vec_data(vdat), .vec_fetch(fetch), .vec_fetch_addr(faddr), .vec_ack(ack),
        .handler(handler));
    initial forever #5 clk = ~clk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // spare edge after each strobe, so no strobe is assigned twice at one edge
    task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d);
        if (!w)
            exq.push_back({24'h000000, d});
        a <= ad;
        wd <= d;
        {wr, rd} <= {w, !w};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        @(posedge clk);
    endtask : bus
    // model answers in a fixed four edges, six is ample
    task automatic take_vec(input logic [4:0] c);
        exq.push_back({16'hFFFE - {10'h000, c, 1'b0}, HANDLER_PAGE, c, 8'h00});
        take <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(exq.size(), 0)
    endtask : take_vec
    // winner among maskable codes 7 to 20, 1F when none
    function automatic logic [4:0] pick(input logic [16:0] q, input logic [4:0] pr);
        logic [20:0] pc;
        logic [4:0]  c;
        pc = {|q[16:13], q[12:0], 7'h00};
        c = 5'h1F;
        for (int i = 20; i >= 7; i--)
            if (pc[i])
                c = 5'(i);
        // reserved codes promote the pin, never pending here
        if (pr >= 5'h07 && pr <= 5'h14 && pc[pr])
            c = pr;
        return c;
    endfunction : pick
    initial
    begin
        logic [4:0]  p;
        logic [4:0]  c;
        logic [16:0] f;
        logic [16:0] m;
        logic        r;
        int          n;
        void'($urandom(382));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, ADDR_SYS_OPTIONS, SYS_OPTIONS_RESET);
        bus(1'b1, ADDR_SYS_OPTIONS, 8'h2C);
        bus(1'b0, ADDR_SYS_OPTIONS, 8'h2C);
        bus(1'b1, ADDR_SYS_OPTIONS, 8'h00);
        bus(1'b0, ADDR_SYS_OPTIONS, 8'h24);
        `CHK(mon, 1'b1)
        bus(1'b1, 8'h00, 8'hFF);
        bus(1'b0, 8'h00, 8'h00);
        take_vec(CODE_EXT_RESET);
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        r = 1'b0;
        repeat (3) @(posedge clk) r = r | resume;
        `CHK(r, 1'b1)
        xmask <= 1'b0;
        for (int k = 1; k <= 5; k++)
        begin
            {xpin_n, swi, ill, wdf, cmf} <= {k != 5, k == 4, k == 3, k == 2, k == 1};
            @(posedge clk);
            {wdf, cmf} <= 2'b00;
            @(posedge clk);
            `CHK(sreq, k <= 2)
            repeat (5) @(posedge clk);
            take_vec(5'(k));
            {xpin_n, swi, ill} <= 3'b100;
            repeat (6) @(posedge clk);
        end
        imask <= 1'b0;
        irq_n <= 1'b0;
        repeat (8) @(posedge clk);
        take_vec(CODE_EXT_IRQ);
        `CHK(pend, 1'b0)
        irq_n <= 1'b1;
        rxs <= 1'b1;
        @(posedge clk);
        rxs <= 1'b0;
        bus(1'b0, ADDR_SERIAL_DATA, 8'h00);
        bus(1'b0, ADDR_SERIAL_STATUS, 8'h20);
        `CHK(rx_full, 1'b1)
        bus(1'b0, ADDR_SERIAL_DATA, 8'h00);
        @(posedge clk);
        `CHK(rx_full, 1'b0)
        repeat (24)
        begin
            p = 5'($urandom);
            f = 17'($urandom);
            m = 17'($urandom);
            fl <= f;
            en <= m;
            imask <= 1'b1;
            bus(1'b1, ADDR_PROMOTED_SEL, {3'h0, p});
            `CHK(pend, 1'b0)
            imask <= 1'b0;
            // dropped: mask is clear at this write
            bus(1'b1, ADDR_PROMOTED_SEL, 8'h14);
            c = pick(f & m, p);
            if (c == 5'h1F)
                `CHK(pend, 1'b0)
            else
                take_vec(c);
            fl <= 17'h00000;
            repeat (3) @(posedge clk);
        end
        // mid-run reset in special mode: protected bits stay writable, exit delay back on
        rst_n <= 1'b0;
        spec <= 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        take_vec(CODE_EXT_RESET);
        bus(1'b1, ADDR_SYS_OPTIONS, 8'h20);
        bus(1'b1, ADDR_SYS_OPTIONS, 8'hD3);
        bus(1'b0, ADDR_SYS_OPTIONS, 8'hD3);
        `CHK(optq, 4'hF)
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        n = 0;
        while (!resume && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        // plus one: the pulse is read at the edge after it is launched
        `CHK(n, STOP_DELAY_CYCLES + 1)
        tally_and_finish();
    end
    always @(posedge clk)
    begin
        rd_q <= rd;
        if (rd_q || ack)
            e = (exq.size() != 0) ? exq.pop_front() : 32'hXXXXXXXX;
        if (ack)
            `CHK({vaddr, handler}, e)
        if (rd_q)
            `CHK({24'h000000, rdat}, e)
    end
endmodule : reset_irq_vectoring_test
